// ===== core/wrs_regs.vh
// Constants for the wake and reset sequencer: offsets, fields, vectors and counts.
`ifndef WRS_REGS_VH
`define WRS_REGS_VH
`define WRS_ADDR_CTRL 12'h0000
`define WRS_ADDR_STATUS 12'h0004
`define WRS_ADDR_RSTAT 12'h0008
`define WRS_ADDR_PWT 12'h000C
`define WRS_ADDR_WDOG 12'h0010
`define WRS_CTRL_SSR 0
`define WRS_CTRL_OSC 1
`define WRS_CTRL_PWT_EN 2
`define WRS_RS_LVI 1
`define WRS_RS_ILAD 2
`define WRS_RS_ILOP 3
`define WRS_RS_WDOG 4
`define WRS_RS_PIN 6
`define WRS_RS_POR 7
`define WRS_VEC_RESET 16'hFFFE
`define WRS_VEC_SWI 16'hFFFC
`define WRS_VEC_IRQ 16'hFFFA
`define WRS_VEC_PLL 16'hFFF8
`define WRS_VEC_T1C0 16'hFFF6
`define WRS_VEC_T1C1 16'hFFF4
`define WRS_VEC_T1OV 16'hFFF2
`define WRS_VEC_T2C0 16'hFFF0
`define WRS_VEC_T2OV 16'hFFEC
`define WRS_VEC_SPRX 16'hFFEA
`define WRS_VEC_SPTX 16'hFFE8
`define WRS_VEC_SCER 16'hFFE6
`define WRS_VEC_SCRX 16'hFFE4
`define WRS_VEC_SCTX 16'hFFE2
`define WRS_VEC_KEY 16'hFFDE
`define WRS_VEC_PWT 16'hFFDC
`define WRS_STAB_CYC 4096
`define WRS_SHORT_CYC 32
`define WRS_PIN_CYC 32
`define WRS_HOLD_CYC 32
`define WRS_FETCH_CYC 64
`endif

// ===== core/wrs_counter.v
// Down counter used for stabilisation and reset pin timing.
`timescale 1ns/1ps
module wrs_counter #(
  parameter WIDTH = 13
) (
  input wire core_clk,
  input wire srst,
  input wire ce,
  input wire load,
  input wire [WIDTH-1:0] load_value,
  output reg [WIDTH-1:0] count,
  output wire done
);
  assign done = (count == {WIDTH{1'b0}});
  always @(posedge core_clk) begin
    if (srst) begin
      count <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (load) begin
        count <= load_value;
      end else if (!done) begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== core/wrs_sequencer.v
// Wake and reset sequencer with APB register access.
// Notes on behaviour
// [RL1] Wake timer runs in wait, register hidden.
// [RL2] Wake timer register hidden during stop.
// [RL3] Wake timer runs in stop only with oscillator.
// [RL4] Wake timer rollover wakes, vector FFDC.
// [RL5] Wait exit restarts clock; resets vector FFFE.
// [RL6] Interrupt pin falling edge vectors FFFA.
// [RL7] Break wakes wait or stop, vector FFFC.
// [RL8] PLL request ends wait, vector FFF8.
// [RL9] First timer vectors FFF2, FFF4, FFF6.
// [RL10] Second timer vectors FFEC, FFF0.
// [RL11] Sync serial vectors FFE8 transmit, FFEA receive.
// [RL12] Async serial vectors FFE2, FFE4, FFE6.
// [RL13] Keypad and converter share vector FFDE.
// [RL14] Only listed events end stop.
// [RL15] Keypad falling edge in stop vectors FFDE.
// [RL16] Stop recovery holds clocks 4096 cycles.
// [RL17] Short recovery option gives 32 cycles.
// [RL18] Crystal users keep short recovery cleared.
// [RL19] Reset aborts, clears bits, fetches FFFE.
// [RL20] Long pin low resets, sets pin flag.
// [RL21] Internal reset: pin low 32, hold 32.
// [RL22] Power-on: 4096 delay, pin+32, fetch+64.
// [RL23] Watchdog overflow resets unless written.
// [RL24] Undervoltage holds pin until stable plus delay.
// [RL25] Reset status read clears, flags accumulate.
// [RL26] Reset wins over simultaneous interrupt.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "wrs_regs.vh"
module wrs_sequencer #(
  parameter STAB_CYC = `WRS_STAB_CYC,
  parameter WDOG_CYC = 262144,
  parameter PWT_DIV = 8192,
  parameter PIN_LOW_MIN = 2
) (
  input wire core_clk,
  input wire srst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire wait_req,
  input wire stop_req,
  input wire rst_pin_in,
  output reg rst_pin_out,
  output reg rst_pin_oe,
  input wire undervoltage,
  input wire illegal_opcode,
  input wire illegal_address,
  input wire irq_pin,
  input wire [3:0] keypad_pins,
  input wire break_req,
  input wire pll_req,
  input wire [2:0] first_timer_req,
  input wire [1:0] second_timer_req,
  input wire [1:0] sync_serial_req,
  input wire [2:0] async_serial_req,
  input wire adc_req,
  output reg cpu_clk_en,
  output reg sys_clk_en,
  output reg core_reset,
  output reg [15:0] vector_addr,
  output reg vector_load,
  output reg [1:0] bus_clk_div_sel,
  output reg wait_active,
  output reg stop_active
);
  localparam ST_RUN = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_STOP = 3'd2;
  localparam ST_RECOV = 3'd3;
  localparam ST_RSTPIN = 3'd4;
  localparam ST_RSTHOLD = 3'd5;
  localparam ST_STAB = 3'd6;
  localparam integer STAB_M1 = STAB_CYC - 1;
  localparam integer SHORT_M1 = `WRS_SHORT_CYC - 1;
  localparam integer PIN_M1 = `WRS_PIN_CYC - 1;
  localparam integer HOLD_M1 = `WRS_HOLD_CYC - 1;
  localparam integer FETCH_M1 = `WRS_FETCH_CYC - `WRS_PIN_CYC - 1;
  localparam [12:0] STAB_LD = STAB_M1[12:0];
  localparam [12:0] SHORT_LD = SHORT_M1[12:0];
  localparam [12:0] PIN_LD = PIN_M1[12:0];
  localparam [12:0] HOLD_LD = HOLD_M1[12:0];
  localparam [12:0] FETCH_LD = FETCH_M1[12:0];
  reg [2:0] state;
  reg [2:0] ctrl;
  reg [7:0] rstat;
  reg [15:0] pwt_count;
  reg [17:0] wdog_count;
  reg irq_q;
  reg [3:0] key_q;
  reg [3:0] pin_low_cnt;
  reg por_done;
  reg stab_is_uv;
  reg cnt_load;
  reg [12:0] cnt_value;
  reg [15:0] pend_vec;
  wire [12:0] cnt;
  wire cnt_done;
  wire irq_fall;
  wire key_fall;
  wire pwt_roll;
  wire pwt_run;
  wire wdog_roll;
  wire ext_reset;
  wire int_reset;
  wire apb_acc;
  wire rd_rstat;
  wire wr_wdog;
  wire pwt_hidden;
  reg [15:0] wake_vec;
  reg wake_any;
  reg stop_wake;
  //////////////////////////////////////////////////////////////////////////////
  // Event detection.
  assign irq_fall = irq_q & ~irq_pin; // [RL6]
  assign key_fall = |(key_q & ~keypad_pins); // [RL15]
  assign pwt_run = ctrl[`WRS_CTRL_PWT_EN] & (state != ST_STOP | ctrl[`WRS_CTRL_OSC]); // [RL1] [RL3]
  assign pwt_roll = pwt_run & (pwt_count == PWT_DIV - 1);
  assign wdog_roll = (wdog_count == WDOG_CYC - 1) & (state != ST_STOP); // [RL23]
  assign ext_reset = (pin_low_cnt >= PIN_LOW_MIN) & ~rst_pin_oe; // [RL20]
  assign int_reset = undervoltage | wdog_roll | illegal_opcode | illegal_address;
  assign apb_acc = psel & penable & ~pready;
  assign rd_rstat = apb_acc & ~pwrite & (paddr == `WRS_ADDR_RSTAT);
  assign wr_wdog = apb_acc & pwrite & (paddr == `WRS_ADDR_WDOG);
  // Stop recovery still counts as stop, so the timer stays hidden until the core runs.
  assign pwt_hidden = wait_active | stop_active; // [RL1] [RL2]
  //////////////////////////////////////////////////////////////////////////////
  // Wake source selection, highest priority first.
  always @* begin
    wake_vec = `WRS_VEC_PWT;
    wake_any = 1'b1;
    if (break_req) wake_vec = `WRS_VEC_SWI; // [RL7]
    else if (irq_fall) wake_vec = `WRS_VEC_IRQ; // [RL6]
    else if (pll_req) wake_vec = `WRS_VEC_PLL; // [RL8]
    else if (first_timer_req[0]) wake_vec = `WRS_VEC_T1C0; // [RL9]
    else if (first_timer_req[1]) wake_vec = `WRS_VEC_T1C1; // [RL9]
    else if (first_timer_req[2]) wake_vec = `WRS_VEC_T1OV; // [RL9]
    else if (second_timer_req[0]) wake_vec = `WRS_VEC_T2C0; // [RL10]
    else if (second_timer_req[1]) wake_vec = `WRS_VEC_T2OV; // [RL10]
    else if (sync_serial_req[1]) wake_vec = `WRS_VEC_SPRX; // [RL11]
    else if (sync_serial_req[0]) wake_vec = `WRS_VEC_SPTX; // [RL11]
    else if (async_serial_req[2]) wake_vec = `WRS_VEC_SCER; // [RL12]
    else if (async_serial_req[1]) wake_vec = `WRS_VEC_SCRX; // [RL12]
    else if (async_serial_req[0]) wake_vec = `WRS_VEC_SCTX; // [RL12]
    else if (key_fall | adc_req) wake_vec = `WRS_VEC_KEY; // [RL13]
    else if (pwt_roll) wake_vec = `WRS_VEC_PWT; // [RL4]
    else wake_any = 1'b0;
    stop_wake = 1'b1;
    if (break_req) stop_wake = 1'b1; // [RL14]
    else if (irq_fall) stop_wake = 1'b1;
    else if (key_fall) stop_wake = 1'b1;
    else if (pwt_roll) stop_wake = 1'b1;
    else stop_wake = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Timing counter.
  wrs_counter #(
    .WIDTH(13)
  ) u_cnt (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .load(cnt_load),
    .load_value(cnt_value),
    .count(cnt),
    .done(cnt_done)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  always @(posedge core_clk) begin
    if (srst) begin
      state <= ST_STAB;
      por_done <= 1'b0;
      stab_is_uv <= 1'b0;
      cnt_load <= 1'b1;
      cnt_value <= STAB_LD;
      pend_vec <= `WRS_VEC_RESET;
      rstat <= 8'h80;
      ctrl <= 3'b000;
      pwt_count <= 16'h0000;
      wdog_count <= 18'h0_0000;
      irq_q <= 1'b1;
      key_q <= 4'hF;
      pin_low_cnt <= 4'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b1;
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b0;
      core_reset <= 1'b1;
      vector_addr <= `WRS_VEC_RESET;
      vector_load <= 1'b0;
      bus_clk_div_sel <= 2'd2;
      wait_active <= 1'b0;
      stop_active <= 1'b0;
    end else if (ce) begin
      irq_q <= irq_pin;
      key_q <= keypad_pins;
      cnt_load <= 1'b0;
      vector_load <= 1'b0;
      pready <= apb_acc;
      pslverr <= 1'b0;
      // A low pin counts only while the device itself lets go of it.
      if (!rst_pin_in && !rst_pin_oe) begin
        if (pin_low_cnt != 4'hF) pin_low_cnt <= pin_low_cnt + 4'h1; // [RL20]
      end else begin
        pin_low_cnt <= 4'h0;
      end
      if (pwt_run) pwt_count <= pwt_roll ? 16'h0000 : pwt_count + 16'h0001;
      if (wr_wdog || core_reset || wdog_roll) wdog_count <= 18'h0_0000; // [RL23]
      else if (state != ST_STOP) wdog_count <= wdog_count + 18'h0_0001;
      // Register reads and writes.
      if (apb_acc) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `WRS_ADDR_CTRL: begin
            if (pwrite) ctrl <= pwdata[2:0];
            else prdata <= {29'h0, ctrl};
          end
          `WRS_ADDR_STATUS: prdata <= {29'h0, state};
          `WRS_ADDR_RSTAT: begin
            if (pwrite) pslverr <= 1'b1; // [RL25]
            else prdata <= {24'h0, rstat};
          end
          `WRS_ADDR_PWT: begin
            if (pwt_hidden || pwrite) pslverr <= 1'b1; // [RL1] [RL2]
            else prdata <= {16'h0, pwt_count};
          end
          `WRS_ADDR_WDOG: if (!pwrite) prdata <= {14'h0, wdog_count};
          default: pslverr <= 1'b1;
        endcase
      end
      // Flags accumulate; a new reset cause wins over a read clear.
      if (rd_rstat) rstat <= 8'h00; // [RL25]
      if (ext_reset && state != ST_STAB) rstat[`WRS_RS_PIN] <= 1'b1; // [RL20]
      if (wdog_roll) rstat[`WRS_RS_WDOG] <= 1'b1; // [RL23]
      if (illegal_opcode) rstat[`WRS_RS_ILOP] <= 1'b1; // [RL21]
      if (illegal_address) rstat[`WRS_RS_ILAD] <= 1'b1; // [RL21]
      if (undervoltage) rstat[`WRS_RS_LVI] <= 1'b1; // [RL24]
      // A reset after power-on aborts everything and wins over wakes; an internal reset does not restart the pin or hold phase.
      if (por_done && (undervoltage || ext_reset)) begin // [RL26]
        state <= ST_STAB; // [RL19] [RL24]
        stab_is_uv <= 1'b1;
        cnt_load <= 1'b1;
        cnt_value <= STAB_LD;
        ctrl <= 3'b000;
        core_reset <= 1'b1;
        cpu_clk_en <= 1'b0;
        sys_clk_en <= 1'b0;
        rst_pin_oe <= undervoltage;
        bus_clk_div_sel <= 2'd2; // [RL19]
        wait_active <= 1'b0;
        stop_active <= 1'b0;
        pend_vec <= `WRS_VEC_RESET; // [RL5]
      end else if (por_done && int_reset && state != ST_RSTPIN && state != ST_RSTHOLD) begin
        state <= ST_RSTPIN; // [RL21] [RL26]
        cnt_load <= 1'b1;
        cnt_value <= PIN_LD;
        ctrl <= 3'b000;
        core_reset <= 1'b1;
        rst_pin_oe <= 1'b1;
        cpu_clk_en <= 1'b0;
        bus_clk_div_sel <= 2'd2;
        wait_active <= 1'b0;
        stop_active <= 1'b0;
        pend_vec <= `WRS_VEC_RESET;
      end else begin
        case (state)
          ST_STAB: begin
            // Hold clocks off; undervoltage stalls the delay until supply recovers.
            if (undervoltage) begin
              cnt_load <= 1'b1; // [RL24]
              cnt_value <= STAB_LD;
            end else if (cnt_done && !cnt_load) begin
              state <= ST_RSTPIN; // [RL22]
              cnt_load <= 1'b1;
              cnt_value <= PIN_LD;
              sys_clk_en <= 1'b1;
            end
          end
          ST_RSTPIN: if (cnt_done && !cnt_load) begin
            rst_pin_oe <= 1'b0; // [RL21] [RL22]
            state <= ST_RSTHOLD;
            cnt_load <= 1'b1;
            cnt_value <= (por_done && !stab_is_uv) ? HOLD_LD : FETCH_LD;
          end
          ST_RSTHOLD: if (cnt_done && !cnt_load) begin
            state <= ST_RUN; // [RL19]
            por_done <= 1'b1;
            stab_is_uv <= 1'b0;
            core_reset <= 1'b0;
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
            vector_addr <= `WRS_VEC_RESET;
            vector_load <= 1'b1;
          end
          ST_RUN: begin
            if (stop_req) begin
              state <= ST_STOP;
              cpu_clk_en <= 1'b0;
              sys_clk_en <= 1'b0;
              stop_active <= 1'b1;
            end else if (wait_req) begin
              state <= ST_WAIT;
              cpu_clk_en <= 1'b0;
              wait_active <= 1'b1;
            end
          end
          ST_WAIT: if (wake_any) begin
            state <= ST_RUN; // [RL5]
            cpu_clk_en <= 1'b1;
            wait_active <= 1'b0;
            vector_addr <= wake_vec;
            vector_load <= 1'b1;
          end
          ST_STOP: if (stop_wake) begin
            state <= ST_RECOV; // [RL14]
            pend_vec <= wake_vec;
            cnt_load <= 1'b1;
            cnt_value <= ctrl[`WRS_CTRL_SSR] ? SHORT_LD : STAB_LD; // [RL16] [RL17]
          end
          ST_RECOV: if (cnt_done && !cnt_load) begin
            state <= ST_RUN; // [RL16]
            stop_active <= 1'b0;
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
            vector_addr <= pend_vec;
            vector_load <= 1'b1;
          end
          default: state <= ST_RUN;
        endcase
      end
    end
  end
endmodule

// ===== tb/wrs_sequencer_props.sv
// Port checker of the wake and reset sequencer.
`timescale 1ns/1ps
module wrs_sequencer_props (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire rst_pin_out,
  input wire rst_pin_oe,
  input wire undervoltage,
  input wire cpu_clk_en,
  input wire core_reset,
  input wire [15:0] vector_addr,
  input wire vector_load,
  input wire [1:0] bus_clk_div_sel,
  input wire wait_active,
  input wire stop_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire acc = psel && penable && pready;
  property p_pin_zero; rst_pin_out == 1'b0; endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("reset pin high");
  property p_hold; $fell(rst_pin_oe) |-> core_reset [*8]; endproperty
  a_hold: assert property (p_hold) else $error("hold after pin too short");
  property p_fetch; $fell(rst_pin_oe) |-> ##[24:40] (vector_load && vector_addr == 16'hFFFE);
  endproperty
  a_fetch: assert property (p_fetch) else $error("reset fetch late");
  property p_div; $fell(core_reset) |-> bus_clk_div_sel == 2'h2; endproperty
  a_div: assert property (p_div) else $error("bus divider wrong");
  property p_wait_clk; wait_active |-> !cpu_clk_en; endproperty
  a_wait_clk: assert property (p_wait_clk) else $error("clock on in wait");
  property p_stop_clk; stop_active |-> !cpu_clk_en; endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clock on in stop");
  property p_ro_status; acc && pwrite && paddr == 12'h008 |-> pslverr; endproperty
  a_ro_status: assert property (p_ro_status) else $error("status write taken");
  property p_hidden; acc && paddr == 12'h00C && $past(wait_active || stop_active) |->
    pslverr; endproperty
  a_hidden: assert property (p_hidden) else $error("timer visible");
  property p_uv_pin; undervoltage [*3] |-> rst_pin_oe; endproperty
  a_uv_pin: assert property (p_uv_pin) else $error("pin free in undervoltage");
endmodule
bind wrs_sequencer wrs_sequencer_props wrs_sequencer_props_inst (.core_clk(core_clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
  .undervoltage(undervoltage), .cpu_clk_en(cpu_clk_en), .core_reset(core_reset),
  .vector_addr(vector_addr), .vector_load(vector_load), .bus_clk_div_sel(bus_clk_div_sel),
  .wait_active(wait_active), .stop_active(stop_active));

// ===== tb/wrs_core_model.sv
// Core model: holds a wait or stop request until the sequencer takes it.
`timescale 1ns/1ps
module wrs_core_model (
  input wire core_clk,
  input wire srst,
  input wire go_wait,
  input wire go_stop,
  input wire taken,
  output reg wait_req,
  output reg stop_req
);
  always @(posedge core_clk) begin
    if (srst || taken) begin
      wait_req <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      wait_req <= wait_req || go_wait;
      stop_req <= stop_req || go_stop;
    end
  end
endmodule

// ===== tb/wrs_sequencer_tb.sv
// Self-checking bench of the wake and reset sequencer.
`timescale 1ns/1ps
module wrs_sequencer_tb;
  reg core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, irq_pin = 1;
  reg undervoltage = 0, ilop = 0, go_wait = 0, go_stop = 0, ext_low = 0, ce = 1, ilad = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [3:0] keypad_pins = 4'hF;
  reg [12:0] src = 0;
  reg err;
  wire [31:0] prdata;
  wire [15:0] vector_addr;
  wire [1:0] bus_clk_div_sel;
  wire pready, pslverr, rst_pin_out, rst_pin_oe, cpu_clk_en, sys_clk_en, core_reset;
  wire vector_load, wait_active, stop_active, wait_req, stop_req;
  wire rst_pin_in = !(rst_pin_oe || ext_low);
  integer num_errors = 0, check_count = 0, i, n, t;
  reg [239:0] vt = {16'hFFDE, 16'hFFFA, 16'hFFDE, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFEA,
    16'hFFE8, 16'hFFEC, 16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6, 16'hFFF8, 16'hFFFC};
  wrs_sequencer #(.STAB_CYC(64), .WDOG_CYC(2000), .PWT_DIV(16), .PIN_LOW_MIN(2))
  wrs_sequencer_inst (.core_clk(core_clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_req(wait_req), .stop_req(stop_req),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .undervoltage(undervoltage), .illegal_opcode(ilop), .illegal_address(ilad),
    .irq_pin(irq_pin), .keypad_pins(keypad_pins), .break_req(src[0]), .pll_req(src[1]),
    .first_timer_req(src[4:2]), .second_timer_req(src[6:5]), .sync_serial_req(src[8:7]),
    .async_serial_req(src[11:9]), .adc_req(src[12]), .cpu_clk_en(cpu_clk_en),
    .sys_clk_en(sys_clk_en), .core_reset(core_reset), .vector_addr(vector_addr),
    .vector_load(vector_load), .bus_clk_div_sel(bus_clk_div_sel),
    .wait_active(wait_active), .stop_active(stop_active));
  wrs_core_model wrs_core_model_inst (.core_clk(core_clk), .srst(srst), .go_wait(go_wait),
    .go_stop(go_stop), .taken(wait_active || stop_active || core_reset),
    .wait_req(wait_req), .stop_req(stop_req));
  initial forever #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    begin
      if (num_errors == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk_rng(input string nm, input integer lo, input integer hi, input integer g);
    begin
      check_count = check_count + 1;
      if (g < lo || g > hi) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge core_clk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
    end
  endtask
  task wvec(input integer lim);
    begin
      n = 0;
      @(posedge core_clk);
      while (vector_load !== 1'b1 && n < lim) begin
        n = n + 1;
        @(posedge core_clk);
      end
      rd = vector_addr;
    end
  endtask
  task enter(input s, input [31:0] c);
    begin
      apb(1, 12'h010, 0);
      apb(1, 12'h000, c);
      go_wait <= !s;
      go_stop <= s;
      @(posedge core_clk);
      go_wait <= 0;
      go_stop <= 0;
      cyc(6);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(40000);
    num_errors = num_errors + 1;
    stop_test;
  end
  initial begin
    cyc(5);
    srst <= 0;
    wvec(1000);
    chk("reset vector", 16'hFFFE, rd);
    chk_rng("power-on delay", 120, 140, n);
    chk("bus divider", 2'h2, bus_clk_div_sel);
    apb(0, 12'h008, 0);
    chk("power-on flags", 32'h0000_0080, rd);
    apb(0, 12'h008, 0);
    chk("flags after read", 0, rd);
    apb(1, 12'h008, 0);
    chk("status write error", 1, err);
    apb(0, 12'h0FC, 0);
    chk("unmapped error", 1, err);
    for (i = 0; i < 15; i = i + 1) begin
      enter(0, 0);
      apb(0, 12'h00C, 0);
      chk("timer hidden in wait", 1, err);
      if (i < 13)
        src <= 13'h0001 << i;
      else if (i == 13)
        irq_pin <= 0;
      else
        keypad_pins <= 4'hE;
      wvec(20);
      chk("wait vector", vt[i*16 +: 16], rd);
      src <= 0;
      irq_pin <= 1;
      keypad_pins <= 4'hF;
      cyc(4);
      chk("wait left", 0, wait_active);
    end
    enter(0, 0);
    ce <= 0;
    src <= 13'h0001;
    cyc(6);
    chk("state frozen by enable", 1, wait_active);
    ce <= 1;
    wvec(20);
    chk("break after enable", 16'hFFFC, rd);
    src <= 0;
    enter(1, 32'h0000_0001);
    src <= 13'h0002;
    cyc(40);
    chk("stop kept on request", 1, stop_active);
    src <= 0;
    irq_pin <= 0;
    wvec(200);
    chk("stop irq vector", 16'hFFFA, rd);
    chk_rng("short recovery", 32, 40, n);
    irq_pin <= 1;
    enter(1, 0);
    keypad_pins <= 4'hE;
    wvec(300);
    chk("stop keypad vector", 16'hFFDE, rd);
    chk_rng("full recovery", 64, 72, n);
    keypad_pins <= 4'hF;
    enter(1, 32'h0000_0001);
    src <= 13'h0001;
    wvec(200);
    chk("stop break vector", 16'hFFFC, rd);
    src <= 0;
    enter(1, 32'h0000_0007);
    apb(0, 12'h00C, 0);
    chk("timer hidden in stop", 1, err);
    wvec(1500);
    chk("wake timer vector", 16'hFFDC, rd);
    t = n;
    enter(1, 32'h0000_0005);
    cyc(2 * t + 50);
    chk("no timer wake without oscillator", 1, stop_active);
    src <= 13'h0001;
    wvec(200);
    src <= 0;
    enter(0, 0);
    src <= 13'h0002;
    ilop <= 1;
    @(posedge core_clk);
    ilop <= 0;
    wvec(400);
    src <= 0;
    chk("reset over interrupt", 16'hFFFE, rd);
    chk_rng("internal reset span", 60, 76, n);
    wvec(2600);
    chk("watchdog vector", 16'hFFFE, rd);
    apb(0, 12'h008, 0);
    chk("accumulated flags", 32'h0000_0018, rd);
    undervoltage <= 1;
    cyc(10);
    chk("pin low in undervoltage", 1, rst_pin_oe);
    undervoltage <= 0;
    wvec(400);
    chk_rng("undervoltage recovery", 120, 140, n);
    apb(0, 12'h008, 0);
    chk("undervoltage flag", 32'h0000_0002, rd);
    ext_low <= 1;
    cyc(4);
    ext_low <= 0;
    wvec(400);
    chk("pin reset vector", 16'hFFFE, rd);
    apb(0, 12'h008, 0);
    chk("pin flag", 32'h0000_0040, rd);
    ilad <= 1;
    @(posedge core_clk);
    ilad <= 0;
    wvec(400);
    chk_rng("address reset span", 60, 76, n);
    apb(0, 12'h008, 0);
    chk("address flag", 32'h0000_0004, rd);
    stop_test;
  end
endmodule
